// [ast_transceiver.v]
// Full-duplex asynchronous serial transceiver with baud generator, FIFOs and register port.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
// How it works
// - Full-duplex, 8 or 9 data bits.
// - Even, odd or no parity, 8-bit.
// - One or two stop bits.
// - Four-deep transmit and receive FIFOs.
// - Parity, framing, overrun flags.
// - Ninth bit one marks an address.
// - Free-running 16-bit baud timer.
// - Standard: clock/(16*(divisor+1)).
// - High speed: clock/(4*(divisor+1)).
// - Divisor write clears baud timer.
// - Enable raises interrupt two cycles later.
// - Idle write loads shifter at once.
// - Preloaded data starts on enable.
// - 9-bit mode takes word writes only.
// - Break request turns dummy into break.
// - Break request self-clears after break.
// - Receive interrupt per mode.
// - Only software clears overrun flag.
// - Data read pops, flags follow head.
// - Baud clock only in 16x mode.
// - Pin field 11 outputs baud clock.
// - Pin field selects pin roles.
// - Format field selects width, parity.
// - Break: start, twelve zeros, stop.
// - Receive interrupt at four, three, any.
`include "ast_regs.vh"

module ast_transceiver (
  // Clock and reset.
  input  wire        clock_in,
  input  wire        rst_in,
  // Register port.
  input  wire [2:0]  addr_in,
  input  wire [15:0] wr_data_in,
  input  wire [1:0]  wr_lane_in,
  input  wire        wr_strobe_in,
  input  wire        rd_strobe_in,
  output reg  [15:0] rd_data_out,
  // Serial pins.
  input  wire        serial_in_pin_in,
  input  wire        clear_to_send_pin_n_in,
  output reg         serial_out_pin_out,
  output reg         serial_out_pin_oe_out,
  output reg         request_to_send_pin_out,
  output reg         request_to_send_pin_oe_out,
  // Interrupt pulses.
  output reg         tx_irq_out,
  output reg         rx_irq_out
);
  // One-hot states of the transmitter and receiver.
  localparam [1:0] TX_IDLE  = 2'b01;
  localparam [1:0] TX_SHIFT = 2'b10;
  localparam [2:0] RX_IDLE  = 3'b001;
  localparam [2:0] RX_START = 3'b010;
  localparam [2:0] RX_DATA  = 3'b100;
  // Software-owned control registers, then the break and overrun flags.
  reg  [15:0] mode_control_reg_q, baud_divisor_reg_q;  // Mode and divisor.
  reg  [1:0]  tx_irq_mode_sel_q, rx_irq_mode_sel_q;    // Interrupt modes.
  reg         addr_detect_q, transmit_enable_q;        // Address detect, transmit enable.
  reg         break_request_q, break_tagged_q;         // Break asked; a queued entry carries it.
  reg         overrun_error_q;                         // Sticky overrun flag.
  // Baud timer, pin clock image and transmit enable history.
  reg  [15:0] baud_cnt_q;
  reg         bclk_q, txen_prev_q;
  reg  [1:0]  txen_dly_q;
  // Transmit FIFO, entries are {break, data[8:0]}.
  reg  [9:0]  tx_mem_q [0:3];
  reg  [1:0]  tx_wr_q, tx_rd_q;
  reg  [2:0]  tx_cnt_q;
  // Transmit shifter; bits left and oversample phase of the bit.
  reg  [1:0]  tx_state_q;
  reg  [15:0] transmit_shift_reg_q;
  reg  [3:0]  tx_bits_q, tx_phase_q;
  reg         tx_was_break_q;                          // Current frame is a break.
  // Receive FIFO, entries are {parity err, framing err, data[8:0]}.
  reg  [10:0] rx_mem_q [0:3];
  reg  [1:0]  rx_wr_q, rx_rd_q;
  reg  [2:0]  rx_cnt_q;
  // Receive shifter; sampled bits arrive at the top.
  reg  [2:0]  rx_state_q;
  reg  [3:0]  rx_phase_q, rx_bits_q;
  reg  [10:0] rx_shift_q;
  // Decoded mode fields.
  wire        enabled    = mode_control_reg_q[`AST_MODE_ENABLE];
  wire [1:0]  pin_enable_field = mode_control_reg_q[`AST_MODE_PIN_HI:`AST_MODE_PIN_LO];
  wire        high_speed_baud_sel = mode_control_reg_q[`AST_MODE_HIGHSPEED];
  wire [1:0]  data_parity_field = mode_control_reg_q[`AST_MODE_FMT_HI:`AST_MODE_FMT_LO];
  wire        two_stop   = mode_control_reg_q[`AST_MODE_TWO_STOP];
  wire        nine_bit   = (data_parity_field == `AST_FMT_NINE);
  wire        has_parity = (data_parity_field == `AST_FMT_ODD) || (data_parity_field == `AST_FMT_EVEN);
  wire [3:0]  ovs_last = high_speed_baud_sel ? `AST_OVS4_LAST : `AST_OVS16_LAST;
  wire [3:0]  ovs_mid  = high_speed_baud_sel ? `AST_OVS4_MID : `AST_OVS16_MID;
  // Register port decode.
  wire        wr_mode  = wr_strobe_in && (addr_in == `AST_ADDR_MODE);
  wire        wr_sta   = wr_strobe_in && (addr_in == `AST_ADDR_STATUS);
  wire        wr_div   = wr_strobe_in && (addr_in == `AST_ADDR_BAUDDIV);
  wire        rd_rx    = rd_strobe_in && (addr_in == `AST_ADDR_RXDATA);
  // word-only writes in 9-bit mode; low byte suffices in 8-bit mode.
  wire        tx_lane_ok = nine_bit ? (wr_lane_in == 2'b11) : wr_lane_in[0];
  wire        wr_tx    = wr_strobe_in && (addr_in == `AST_ADDR_TXDATA) && tx_lane_ok && enabled;
  wire        tx_full  = (tx_cnt_q == `AST_FIFO_DEPTH);
  wire        tx_push  = wr_tx && !tx_full;
  // a rising transmit enable restarts the timer from zero.
  wire        txen_rise = transmit_enable_q && !txen_prev_q;
  // the tick fires when the timer reaches the divisor.
  wire        baud_tick = enabled && (baud_cnt_q == baud_divisor_reg_q);
  // Pin field 10: transmission waits for clear to send.
  wire        cts_ok  = (pin_enable_field != `AST_PINS_FLOW) || !clear_to_send_pin_n_in;
  wire [9:0]  tx_head = tx_mem_q[tx_rd_q];
  // an idle transmitter takes the head entry at once.
  wire        tx_load = enabled && transmit_enable_q && tx_state_q[0] && (tx_cnt_q != 3'h0) && cts_ok;
  // parity bit: even makes the ones count even, odd makes it odd.
  wire        par_bit = (data_parity_field == `AST_FMT_ODD) ? ~^tx_head[7:0] : ^tx_head[7:0];
  wire        bit8    = nine_bit ? tx_head[8] : (has_parity ? par_bit : 1'b1);
  wire        tx_bit_end = tx_state_q[1] && baud_tick && (tx_phase_q == ovs_last);
  wire        tx_done    = tx_bit_end && (tx_bits_q == 4'h1);
  // Receive side.
  wire        rx_line   = serial_in_pin_in;
  wire [3:0]  rx_frame_bits = 4'h9 + {3'h0, nine_bit | has_parity};
  wire        rx_sample = rx_state_q[2] && baud_tick && (rx_phase_q == ovs_last);
  wire        rx_last   = rx_sample && (rx_bits_q == 4'h1);
  wire [10:0] rx_frame  = {rx_line, rx_shift_q[10:1]};
  // Align the frame so data starts at bit 0; the stop bit was sampled last.
  wire [10:0] rx_aligned = (nine_bit | has_parity) ? {1'b1, rx_frame[10:1]} : {2'b11, rx_frame[10:2]};
  wire [8:0]  rx_data   = nine_bit ? rx_aligned[8:0] : {1'b0, rx_aligned[7:0]};
  wire        rx_par_err = has_parity &&
                           (rx_aligned[8] != ((data_parity_field == `AST_FMT_ODD) ? ~^rx_aligned[7:0]
                                                                                  : ^rx_aligned[7:0]));
  // framing error when the stop bit reads low.
  wire        rx_frm_err = !rx_line;
  // address detect in 9-bit mode keeps only ninth-bit-set characters.
  wire        rx_keep   = !(addr_detect_q && nine_bit) || rx_data[8];
  wire        rx_full   = (rx_cnt_q == `AST_FIFO_DEPTH);
  wire        rx_pop    = rd_rx && (rx_cnt_q != 3'h0);
  wire        rx_push   = rx_last && rx_keep && !rx_full;
  wire [10:0] rx_head   = rx_mem_q[rx_rd_q];
  // Control bits written by software.
  always @(posedge clock_in) begin
    if (rst_in) begin
      mode_control_reg_q <= `AST_MODE_RESET;
      baud_divisor_reg_q <= `AST_BAUDDIV_RESET;
      tx_irq_mode_sel_q  <= 2'h0;
      rx_irq_mode_sel_q  <= 2'h0;
      addr_detect_q      <= 1'b0;
      transmit_enable_q  <= 1'b0;
    end else begin
      if (wr_mode) mode_control_reg_q <= wr_data_in;
      if (wr_div) baud_divisor_reg_q <= wr_data_in;
      if (wr_sta) begin
        tx_irq_mode_sel_q <= {wr_data_in[`AST_STA_TXISEL1], wr_data_in[`AST_STA_TXISEL0]};
        rx_irq_mode_sel_q <= wr_data_in[`AST_STA_RXISEL_HI:`AST_STA_RXISEL_LO];
        addr_detect_q     <= wr_data_in[`AST_STA_ADDR_DET];
        transmit_enable_q <= wr_data_in[`AST_STA_TXEN];
      end
    end
  end
  // Break request (software sets, software or break end clears) and overrun flag (receiver sets, software clears).
  always @(posedge clock_in) begin
    if (rst_in) begin
      break_request_q <= 1'b0;
      break_tagged_q  <= 1'b0;
      overrun_error_q <= 1'b0;
    end else begin
      if (tx_done && tx_was_break_q) begin
        break_request_q <= 1'b0;
        break_tagged_q  <= 1'b0;
      end else if (wr_sta) begin
        break_request_q <= wr_data_in[`AST_STA_BREAK];
      end
      // first char after request becomes break.
      if (tx_push && break_request_q && !break_tagged_q) break_tagged_q <= 1'b1;
      if (!transmit_enable_q) break_tagged_q <= 1'b0;
      // software clears overrun; a new overrun in the same cycle wins.
      if (rx_last && rx_keep && rx_full) overrun_error_q <= 1'b1;
      else if (wr_sta && !wr_data_in[`AST_STA_OVERRUN_ERROR_FLAG]) overrun_error_q <= 1'b0;
    end
  end
  // Baud timer: wraps at the divisor, one tick per divisor+1 cycles.
  always @(posedge clock_in) begin
    if (rst_in) begin
      baud_cnt_q  <= 16'h0000;
      bclk_q      <= 1'b0;
      txen_prev_q <= 1'b0;
      txen_dly_q  <= 2'h0;
    end else begin
      txen_prev_q <= transmit_enable_q;
      txen_dly_q  <= {txen_dly_q[0], txen_rise};
      if (wr_div || txen_rise || baud_tick || !enabled) begin
        baud_cnt_q <= 16'h0000;
      end else begin
        baud_cnt_q <= baud_cnt_q + 16'h0001;
      end
      // High in the first half of each tick period; divisor zero holds it high.
      bclk_q <= enabled && (baud_cnt_q <= {1'b0, baud_divisor_reg_q[15:1]});
    end
  end
  // Transmit FIFO; a falling enable empties it, so data may be preloaded while off.
  always @(posedge clock_in) begin
    if (rst_in || (txen_prev_q && !transmit_enable_q)) begin
      tx_wr_q  <= 2'h0;
      tx_rd_q  <= 2'h0;
      tx_cnt_q <= 3'h0;
    end else begin
      if (tx_push) begin
        tx_mem_q[tx_wr_q] <= {break_request_q && !break_tagged_q, wr_data_in[8:0]};
        tx_wr_q           <= tx_wr_q + 2'h1;
      end
      if (tx_load) tx_rd_q <= tx_rd_q + 2'h1;
      tx_cnt_q <= tx_cnt_q + {2'h0, tx_push} - {2'h0, tx_load};
    end
  end
  // Transmit shifter: the line carries bit 0 while shifting.
  always @(posedge clock_in) begin
    if (rst_in || !transmit_enable_q || !enabled) begin
      tx_state_q           <= TX_IDLE;
      transmit_shift_reg_q <= 16'hffff;
      tx_bits_q            <= 4'h0;
      tx_phase_q           <= 4'h0;
      tx_was_break_q       <= 1'b0;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          if (tx_load) begin
            tx_state_q     <= TX_SHIFT;
            tx_phase_q     <= 4'h0;
            tx_was_break_q <= tx_head[9];
            if (tx_head[9]) begin
              // break frame: start, twelve zeros, stop.
              transmit_shift_reg_q <= `AST_BREAK_FRAME;
              tx_bits_q            <= `AST_BREAK_BITS;
            end else begin
              // format picks ninth bit; stop count.
              transmit_shift_reg_q <= {6'h3f, bit8, tx_head[7:0], 1'b0};
              tx_bits_q <= 4'ha + {3'h0, nine_bit | has_parity} + {3'h0, two_stop};
            end
          end
        end
        TX_SHIFT: begin
          if (baud_tick) tx_phase_q <= (tx_phase_q == ovs_last) ? 4'h0 : tx_phase_q + 4'h1;
          if (tx_bit_end) begin
            transmit_shift_reg_q <= {1'b1, transmit_shift_reg_q[15:1]};
            tx_bits_q            <= tx_bits_q - 4'h1;
            if (tx_bits_q == 4'h1) tx_state_q <= TX_IDLE;
          end
        end
        default: begin
          tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end
  // Receiver: find a low line, confirm at mid-bit, sample each bit time.
  always @(posedge clock_in) begin
    if (rst_in || !enabled) begin
      rx_state_q <= RX_IDLE;
      rx_phase_q <= 4'h0;
      rx_bits_q  <= 4'h0;
      rx_shift_q <= 11'h7ff;
    end else begin
      case (rx_state_q)
        RX_IDLE: begin
          if (baud_tick && !rx_line) begin
            rx_state_q <= RX_START;
            rx_phase_q <= 4'h0;
          end
        end
        RX_START: begin
          if (baud_tick) begin
            if (rx_phase_q == ovs_mid) begin
              // A start that has gone high again was a glitch.
              rx_state_q <= rx_line ? RX_IDLE : RX_DATA;
              rx_phase_q <= 4'h0;
              rx_bits_q  <= rx_frame_bits;
            end else begin
              rx_phase_q <= rx_phase_q + 4'h1;
            end
          end
        end
        RX_DATA: begin
          if (baud_tick) rx_phase_q <= (rx_phase_q == ovs_last) ? 4'h0 : rx_phase_q + 4'h1;
          if (rx_sample) begin
            rx_shift_q <= rx_frame;
            rx_bits_q  <= rx_bits_q - 4'h1;
            if (rx_bits_q == 4'h1) rx_state_q <= RX_IDLE;
          end
        end
        default: begin
          rx_state_q <= RX_IDLE;
        end
      endcase
    end
  end
  // Receive FIFO with per-entry error flags.
  always @(posedge clock_in) begin
    if (rst_in) begin
      rx_wr_q  <= 2'h0;
      rx_rd_q  <= 2'h0;
      rx_cnt_q <= 3'h0;
    end else begin
      // full FIFO drops the new char.
      if (rx_push) begin
        rx_mem_q[rx_wr_q] <= {rx_par_err, rx_frm_err, rx_data};
        rx_wr_q           <= rx_wr_q + 2'h1;
      end
      if (rx_pop) rx_rd_q <= rx_rd_q + 2'h1;
      rx_cnt_q <= rx_cnt_q + {2'h0, rx_push} - {2'h0, rx_pop};
    end
  end
  // Interrupt pulses, one cycle each.
  always @(posedge clock_in) begin
    if (rst_in) begin
      tx_irq_out <= 1'b0;
      rx_irq_out <= 1'b0;
    end else begin
      tx_irq_out <= txen_dly_q[0] ||
                    (tx_load && (tx_irq_mode_sel_q == 2'b00)) ||
                    (tx_load && (tx_irq_mode_sel_q == 2'b10) && (tx_cnt_q == 3'h1) && !tx_push) ||
                    (tx_done && (tx_irq_mode_sel_q == 2'b01) && (tx_cnt_q == 3'h0));
      case (rx_irq_mode_sel_q)
        `AST_RXI_FULL:  rx_irq_out <= rx_push && (rx_cnt_q - {2'h0, rx_pop} == 3'h3);
        `AST_RXI_THREE: rx_irq_out <= rx_push && (rx_cnt_q - {2'h0, rx_pop} == 3'h2);
        default:        rx_irq_out <= rx_push;
      endcase
    end
  end
  // Pins: data line and the shared request-to-send / baud clock pin.
  always @(posedge clock_in) begin
    if (rst_in) begin
      serial_out_pin_out         <= 1'b1;
      serial_out_pin_oe_out      <= 1'b0;
      request_to_send_pin_out    <= 1'b1;
      request_to_send_pin_oe_out <= 1'b0;
    end else begin
      serial_out_pin_out    <= transmit_shift_reg_q[0] | tx_state_q[0];
      serial_out_pin_oe_out <= enabled && transmit_enable_q;
      case (pin_enable_field)
        `AST_PINS_BCLK: begin
          request_to_send_pin_out    <= bclk_q && !high_speed_baud_sel;
          request_to_send_pin_oe_out <= enabled;
        end
        `AST_PINS_FLOW, `AST_PINS_RTS: begin
          // Active low: asks for data while the receive FIFO has room.
          request_to_send_pin_out    <= rx_full;
          request_to_send_pin_oe_out <= enabled;
        end
        default: begin
          request_to_send_pin_out    <= 1'b1;
          request_to_send_pin_oe_out <= 1'b0;
        end
      endcase
    end
  end
  // Read data: valid only in the cycle after the read strobe, zero otherwise.
  always @(posedge clock_in) begin
    if (rst_in || !rd_strobe_in) begin
      rd_data_out <= 16'h0000;
    end else begin
      case (addr_in)
        `AST_ADDR_MODE:    rd_data_out <= mode_control_reg_q;
        `AST_ADDR_BAUDDIV: rd_data_out <= baud_divisor_reg_q;
        `AST_ADDR_RXDATA:  rd_data_out <= {7'h00, rx_head[8:0]};
        `AST_ADDR_STATUS: begin
          // each error has its own flag.
          rd_data_out <= {tx_irq_mode_sel_q[1], 1'b0, tx_irq_mode_sel_q[0], 1'b0,
                          break_request_q, transmit_enable_q, tx_full,
                          (tx_cnt_q == 3'h0) && tx_state_q[0],
                          rx_irq_mode_sel_q, addr_detect_q, rx_state_q[0],
                          (rx_cnt_q != 3'h0) && rx_head[10], (rx_cnt_q != 3'h0) && rx_head[9],
                          overrun_error_q, rx_cnt_q != 3'h0};
        end
        default:           rd_data_out <= 16'h0000;
      endcase
    end
  end

endmodule // ast_transceiver

// [ast_regs.vh]
// Register offsets, field positions, reset values and timing counts for the serial transceiver.
`ifndef AST_REGS_VH
`define AST_REGS_VH

// Register offsets on the plain register port (word index).
`define AST_ADDR_MODE       3'h0
`define AST_ADDR_STATUS     3'h1
`define AST_ADDR_TXDATA     3'h2
`define AST_ADDR_RXDATA     3'h3
`define AST_ADDR_BAUDDIV    3'h4

// Mode register fields.
`define AST_MODE_ENABLE     15
`define AST_MODE_PIN_HI     9
`define AST_MODE_PIN_LO     8
`define AST_MODE_HIGHSPEED  3
`define AST_MODE_FMT_HI     2
`define AST_MODE_FMT_LO     1
`define AST_MODE_TWO_STOP   0

// Status register fields.
`define AST_STA_TXISEL1     15
`define AST_STA_TXISEL0     13
`define AST_STA_BREAK       11
`define AST_STA_TXEN        10
`define AST_STA_TXFULL      9
`define AST_STA_TXEMPTY     8
`define AST_STA_RXISEL_HI   7
`define AST_STA_RXISEL_LO   6
`define AST_STA_ADDR_DET    5
`define AST_STA_RXIDLE      4
`define AST_STA_PARITY_ERROR_FLAG        3
`define AST_STA_FRAMING_ERROR_FLAG        2
`define AST_STA_OVERRUN_ERROR_FLAG        1
`define AST_STA_RXAVAIL     0

// Reset values.
`define AST_MODE_RESET      16'h0000
`define AST_STA_CTRL_RESET  16'h0000
`define AST_BAUDDIV_RESET   16'h0000

// Pin usage codes.
`define AST_PINS_BCLK       2'b11
`define AST_PINS_FLOW       2'b10
`define AST_PINS_RTS        2'b01

// Frame format codes.
`define AST_FMT_NINE        2'b11
`define AST_FMT_ODD         2'b10
`define AST_FMT_EVEN        2'b01

// Receive interrupt levels.
`define AST_RXI_FULL        2'b11
`define AST_RXI_THREE       2'b10

// Oversampling: last phase index for 16x and 4x modes, and mid-bit points.
`define AST_OVS16_LAST      4'hf
`define AST_OVS4_LAST       4'h3
`define AST_OVS16_MID       4'h7
`define AST_OVS4_MID        4'h1

// Frame images and lengths; a break is start, twelve zeros, stop.
`define AST_BREAK_FRAME     16'he000
`define AST_BREAK_BITS      4'he
`define AST_FIFO_DEPTH      3'h4
`define AST_TXI_DELAY       2'h2

`endif

// [ast_monitor.sv]
// Port checker for the serial transceiver.
`timescale 1ns/1ps
`include "ast_regs.vh"
module ast_monitor (
  // Clock, reset and register port.
  input wire        clock_in,
  input wire        rst_in,
  input wire [2:0]  addr_in,
  input wire [15:0] wr_data_in,
  input wire [1:0]  wr_lane_in,
  input wire        wr_strobe_in,
  input wire        rd_strobe_in,
  input wire [15:0] rd_data_out,
  // Pins and interrupts.
  input wire        serial_out_pin_out,
  input wire        serial_out_pin_oe_out,
  input wire        request_to_send_pin_out,
  input wire        request_to_send_pin_oe_out,
  input wire        tx_irq_out,
  input wire        rx_irq_out
);
  reg        en_q, hs_q, txen_q, rts_q, rdst_q, overrun_error_flag_q; // Shadows of written bits, of the RTS pin and of a status read.
  reg [1:0]  pin_q, rise_q;                            // Pin field and clock rises since a write.
  reg [3:0]  quiet_q;                                  // Cycles since the last write.
  reg [15:0] div_q, gap_q;                             // Divisor and cycles between clock rises.
  wire       rise = request_to_send_pin_out && !rts_q;
  wire       wst = wr_strobe_in && addr_in == `AST_ADDR_STATUS;
  wire       wmd = wr_strobe_in && addr_in == `AST_ADDR_MODE;
  // Shadows; a write restarts the settle counters as it may move the baud phase.
  always @(posedge clock_in) begin
    rts_q <= request_to_send_pin_out;
    rdst_q <= rd_strobe_in && addr_in == `AST_ADDR_STATUS;
    gap_q <= rise ? 16'h1 : gap_q + 16'h1;
    quiet_q <= wr_strobe_in ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
    rise_q <= wr_strobe_in ? 2'h0 : rise_q + {1'b0, rise && rise_q != 2'h3};
    if (rdst_q && rd_data_out[1]) overrun_error_flag_q <= 1'b1;
    if (wmd) {en_q, pin_q, hs_q} <= {wr_data_in[15], wr_data_in[9:8], wr_data_in[3]};
    if (wst) txen_q <= wr_data_in[10];
    if (wst && !wr_data_in[1]) overrun_error_flag_q <= 1'b0;
    if (wr_strobe_in && addr_in == `AST_ADDR_BAUDDIV) div_q <= wr_data_in;
    if (rst_in) {en_q, hs_q, txen_q, overrun_error_flag_q, pin_q, div_q, quiet_q, rise_q} <= '0;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  tx_irq_delay_a: assert property (
    wst && wr_lane_in[1] && wr_data_in[10] && !txen_q && en_q |-> ##3 tx_irq_out) else $error("tx irq late");
  line_idle_a: assert property (!serial_out_pin_oe_out |-> serial_out_pin_out) else $error("line not idle");
  tx_oe_a: assert property (quiet_q > 4'h1 |-> serial_out_pin_oe_out == (en_q && txen_q)) else $error("tx oe");
  bclk_period_a: assert property (
    rise && rise_q != 2'h0 && en_q && pin_q == 2'b11 && !hs_q |-> gap_q == div_q + 16'h1) else $error("bclk period");
  bclk_fast_off_a: assert property (
    en_q && pin_q == 2'b11 && hs_q && quiet_q > 4'h1 |-> !request_to_send_pin_out) else $error("bclk in 4x");
  rts_oe_a: assert property (
    quiet_q > 4'h1 |-> request_to_send_pin_oe_out == (en_q && pin_q != 2'b00)) else $error("rts oe");
  overrun_error_flag_sticky_a: assert property (rdst_q && overrun_error_flag_q |-> rd_data_out[1]) else $error("overrun lost");
  rx_pulse_a: assert property (rx_irq_out |=> !rx_irq_out) else $error("rx irq long");
  cover property (rise && rise_q != 2'h0);
  cover property (tx_irq_out);
  cover property (rdst_q && rd_data_out[1]);
endmodule // ast_monitor
bind ast_transceiver ast_monitor ast_monitor_i (.*);

// [ast_remote_station.sv]
// Remote serial station that sends and samples frames.
`timescale 1ns/1ps
module ast_remote_station (
  // Clock and lines.
  input  wire clock_in,
  input  wire line_in,
  output reg  line_out,
  output wire cts_n_out
);
  int bit_cycles = 16; // Clock cycles in one bit time.
  initial line_out = 1'b1;
  // Always ready to take data.
  assign cts_n_out = 1'b0;
  // Sends bits LSB first, ending on a stop bit.
  task automatic send(input logic [15:0] bits, input int len);
    for (int i = 0; i < len; i++) begin
      line_out <= bits[i];
      repeat (bit_cycles) @(posedge clock_in);
    end
  endtask
  // Samples at mid-bit; returns at the last mid-bit so no start is missed.
  task automatic capture(input int len, output logic [15:0] bits);
    int w;
    bits = '0;
    w = 0;
    while (line_in !== 1'b0 && w < 20000) begin @(posedge clock_in); w++; end
    repeat (bit_cycles / 2) @(posedge clock_in);
    for (int i = 0; i < len; i++) begin
      bits[i] = line_in;
      if (i < len - 1) repeat (bit_cycles) @(posedge clock_in);
    end
  endtask
endmodule // ast_remote_station

// [ast_transceiver_test.sv]
// Self-checking bench for the serial transceiver.
`timescale 1ns/1ps
`include "ast_regs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module ast_transceiver_test;
  reg          clock_in, rst_in, wr_s, rd_s; // Clock, reset and strobes.
  reg  [2:0]   addr;                         // Register index.
  reg  [15:0]  wdata;                        // Write data.
  reg  [1:0]   lanes;                        // Byte lanes.
  wire [15:0]  rd_data;                      // Read data.
  wire         ser_in, cts_n, ser_out, ser_oe, rts, rts_oe, tx_irq, rx_irq;
  int          num_errors = 0, compares = 0, rx_pulses = 0, n, len;
  logic [8:0]  exp_q[$];                     // Characters the model expects.
  logic [8:0]  d;
  logic [15:0] got, bits, e;
  ast_transceiver ast_transceiver_i (.clock_in, .rst_in, .addr_in(addr), .wr_data_in(wdata), .wr_lane_in(lanes),
    .wr_strobe_in(wr_s), .rd_strobe_in(rd_s), .rd_data_out(rd_data), .serial_in_pin_in(ser_in),
    .clear_to_send_pin_n_in(cts_n), .serial_out_pin_out(ser_out), .serial_out_pin_oe_out(ser_oe),
    .request_to_send_pin_out(rts), .request_to_send_pin_oe_out(rts_oe), .tx_irq_out(tx_irq), .rx_irq_out(rx_irq));
  ast_remote_station ast_remote_station_i (.clock_in, .line_in(ser_out), .line_out(ser_in), .cts_n_out(cts_n));
  initial begin clock_in = 1'b0; forever #12.5 clock_in = ~clock_in; end
  always @(posedge clock_in) if (rx_irq === 1'b1) rx_pulses <= rx_pulses + 1;
  // A write leaves one idle cycle after its strobe.
  task automatic wr(input logic [2:0] a, input logic [15:0] v, input logic [1:0] l = 2'b11);
    addr <= a; wdata <= v; lanes <= l; wr_s <= 1'b1;
    @(posedge clock_in) wr_s <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    addr <= a; rd_s <= 1'b1;
    @(posedge clock_in) rd_s <= 1'b0;
    @(posedge clock_in) v = rd_data;
  endtask
  // Expected frame: start, data, ninth or parity bit, stops.
  function automatic logic [15:0] frame(input logic [8:0] v, input logic [1:0] f, input bit two, output int l);
    frame = {7'h7f, v[7:0], 1'b0};
    if (f != 2'b00) frame[9] = (f == `AST_FMT_NINE) ? v[8] : (^v[7:0]) ^ (f == `AST_FMT_ODD);
    l = 10 + (f != 2'b00) + two;
  endfunction
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin repeat (60000) @(posedge clock_in); num_errors++; wrap_up; end
  initial begin
    {wr_s, rd_s, addr, wdata, lanes} = '0;
    rst_in = 1'b1;
    void'($urandom(56681));
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    rd(`AST_ADDR_BAUDDIV, got);
    `CHK(got, `AST_BAUDDIV_RESET)
    // Divisor 1 at 16x: 32 cycles a bit; baud clock on its pin.
    wr(`AST_ADDR_BAUDDIV, 16'h1);
    wr(`AST_ADDR_MODE, 16'h8300);
    ast_remote_station_i.bit_cycles = 32;
    wr(`AST_ADDR_STATUS, 16'h0400);
    n = 0;
    while (tx_irq !== 1'b1 && n < 8) begin @(posedge clock_in); n++; end
    `CHK(n, 2)
    // Each format and stop count, two characters back to back.
    for (int f = 0; f < 8; f++) begin
      wr(`AST_ADDR_MODE, 16'h8300 | f[2:0]);
      repeat (2) exp_q.push_back(9'($urandom));
      fork
        repeat (2) begin
          e = frame(exp_q[0], f[2:1], f[0], len);
          ast_remote_station_i.capture(len, bits);
          `CHK(bits, e & ((16'h1 << len) - 16'h1))
          void'(exp_q.pop_front());
        end
        for (int k = 0; k < 2; k++) wr(`AST_ADDR_TXDATA, {7'h0, exp_q[k]}, f[2:1] == 2'b11 ? 2'b11 : 2'b01);
      join
      repeat (40) @(posedge clock_in);
    end
    $display("transmit test done");
    // Receive each format; even parity arrives corrupted.
    for (int f = 0; f < 4; f++) begin
      wr(`AST_ADDR_MODE, 16'h8300 | (f[1:0] << 1));
      d = 9'($urandom);
      e = frame(d, f[1:0], 1'b0, len);
      if (f == 1) e[9] = ~e[9];
      ast_remote_station_i.send(e, len);
      repeat (4) @(posedge clock_in);
      rd(`AST_ADDR_STATUS, got);
      `CHK(got[3:0], {f == 1, 3'b001})
      rd(`AST_ADDR_RXDATA, got);
      `CHK({got[8] & (f == 3), got[7:0]}, {d[8] & (f == 3), d[7:0]})
    end
    `CHK(rx_pulses, 4)
    $display("receive test done");
    // Five characters into four places, interrupt on full.
    wr(`AST_ADDR_MODE, 16'h8300);
    wr(`AST_ADDR_STATUS, 16'h04c0);
    n = rx_pulses;
    repeat (5) begin
      exp_q.push_back({1'b0, 8'($urandom)});
      e = frame(exp_q[$], 2'b00, 1'b0, len);
      ast_remote_station_i.send(e, len);
    end
    repeat (4) @(posedge clock_in);
    `CHK(rx_pulses, n + 1)
    rd(`AST_ADDR_STATUS, got);
    `CHK(got[1:0], 2'b11)
    repeat (4) begin
      rd(`AST_ADDR_RXDATA, got);
      `CHK(got[7:0], exp_q.pop_front() & 9'hff)
    end
    exp_q.delete();
    rd(`AST_ADDR_STATUS, got);
    `CHK(got[1:0], 2'b10)
    wr(`AST_ADDR_STATUS, 16'h04c0);
    rd(`AST_ADDR_STATUS, got);
    `CHK(got[1], 1'b0)
    $display("overrun test done");
    // Break with a random dummy, then the sync character.
    wr(`AST_ADDR_STATUS, 16'h0c00);
    fork
      begin
        ast_remote_station_i.capture(14, bits);
        `CHK(bits, 16'h2000)
        ast_remote_station_i.capture(10, bits);
        `CHK(bits, 16'h02aa)
      end
      begin
        wr(`AST_ADDR_TXDATA, 16'($urandom), 2'b01);
        wr(`AST_ADDR_TXDATA, 16'h0055, 2'b01);
      end
    join
    repeat (40) @(posedge clock_in);
    rd(`AST_ADDR_STATUS, got);
    `CHK(got[11], 1'b0)
    $display("break test done");
    // 4x mode with divisor 2: 12 cycles a bit both ways.
    wr(`AST_ADDR_BAUDDIV, 16'h2);
    wr(`AST_ADDR_MODE, 16'h8308);
    ast_remote_station_i.bit_cycles = 12;
    d = {1'b0, 8'($urandom)};
    e = frame(d, 2'b00, 1'b0, len);
    fork
      ast_remote_station_i.capture(10, bits);
      wr(`AST_ADDR_TXDATA, {7'h0, d}, 2'b01);
    join
    `CHK(bits, e & 16'h03ff)
    ast_remote_station_i.send(e, 10);
    repeat (4) @(posedge clock_in);
    rd(`AST_ADDR_RXDATA, got);
    `CHK(got[7:0], d[7:0])
    $display("fast rate test done");
    wrap_up;
  end
endmodule // ast_transceiver_test
